// ===== logic/aic_pkg.sv
package aic_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_ROLE   = 8'h00;
	localparam logic [7:0] ADDR_ED_CFG = 8'h04;
	localparam logic [7:0] ADDR_CO_CFG = 8'h08;
	localparam logic [7:0] ADDR_SDUR   = 8'h0C;
	localparam logic [7:0] ADDR_MASK   = 8'h10;
	localparam logic [7:0] ADDR_PAN    = 8'h14;
	localparam logic [7:0] ADDR_CH     = 8'h18;
	localparam logic [7:0] ADDR_OWN    = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_NET    = 8'h24;

	// Field positions of both association configurations and of the status and network registers.
	localparam int PAN_BIT  = 0;
	localparam int CH_BIT   = 1;
	localparam int AUTO_BIT = 2;
	localparam int POLL_BIT = 3;
	localparam int STATE_BIT = 8;
	localparam int NET_CH_LSB = 16;

	// Association status codes.
	localparam logic [7:0] STAT_OK      = 8'h00;
	localparam logic [7:0] STAT_REFUSED = 8'h03;
	localparam logic [7:0] STAT_NO_RESP = 8'h0C;
	localparam logic [7:0] STAT_UNKNOWN = 8'hFF;

	localparam logic [15:0] BCAST     = 16'hFFFF;
	localparam logic [7:0]  CHAN_BASE = 8'h0B;
	localparam int          NUM_CH    = 16;

	// Timing: one tick per millisecond.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam logic [9:0]  ED_HALF_MS   = 10'h0FA;
	localparam logic [9:0]  CO_HALF_MS   = 10'h1F4;
	localparam logic [15:0] JOIN_WAIT_MS = 16'h01F4;

	typedef enum logic [3:0] {
		ST_START    = 4'b0000,
		ST_PEER     = 4'b0001,
		ST_ASCAN    = 4'b0010,
		ST_ALISTEN  = 4'b0011,
		ST_ESCAN    = 4'b0100,
		ST_ELISTEN  = 4'b0101,
		ST_JOIN     = 4'b0110,
		ST_JOINWAIT = 4'b0111,
		ST_JOINED   = 4'b1000,
		ST_FORM     = 4'b1001,
		ST_FORMED   = 4'b1010
	} aic_state_t;

	typedef struct packed {
		logic        role;
		logic [7:0]  edCfg;
		logic [7:0]  coCfg;
		logic [7:0]  scanDur;
		logic [15:0] mask;
		logic [15:0] pan;
		logic [7:0]  ch;
		logic [15:0] own;
	} aic_cfg_t;

	// PAN identifier reset value is arbitrary.
	localparam aic_cfg_t CFG_RST = '{role: 1'b0, edCfg: 8'h00, coCfg: 8'h00, scanDur: 8'h04,
		mask: 16'hFFFF, pan: 16'h1234, ch: 8'h0C, own: 16'h0000};

	typedef struct packed {
		logic [15:0] panId;
		logic [7:0]  lqi;
	} aic_beacon_t;

	typedef struct packed {
		logic [15:0] dstAddr;
		logic [15:0] dstPan;
		logic [7:0]  chan;
	} aic_scan_req_t;

	typedef struct packed {
		logic [15:0] panId;
		logic [7:0]  chan;
	} aic_net_t;

endpackage

// ===== logic/aic_tick_gen.sv
`timescale 1ns/1ps
module aic_tick_gen #(
	parameter int unsigned CYCLES = 100000
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic sys_rst,
	// One-cycle enable pulse.
	output logic      tick
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r + 32'h0000_0001;
		tick_nxt = 1'b0;
		if (cnt_r == 32'(CYCLES - 1)) begin
			cnt_nxt  = 32'h0000_0000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 32'h0000_0000;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

endmodule // aic_tick_gen

// ===== logic/aic_chan_pick.sv
`timescale 1ns/1ps
module aic_chan_pick #(
	parameter int N = 16
) (
	// Enabled channels and first index to consider.
	input  wire logic [N-1:0] mask,
	input  wire logic [4:0]   from,
	// Lowest enabled index at or above from.
	output logic              found,
	output logic [3:0]        idx
);

	logic [N-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_hit
			assign hit[g] = mask[g] && (5'(g) >= from);
		end
	endgenerate

	always_comb begin
		found = 1'b0;
		idx   = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hit[i]) begin
				found = 1'b1;
				idx   = 4'(i);
			end
		end
	end

endmodule // aic_chan_pick

// ===== logic/aic_assoc_ctrl.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Join only as end device with auto bit
// - Config bits: PAN, channel, auto, wake poll
// - Zero configuration means peer mode
// - Beacon request per channel, listen, advance
// - 0x04 needs matching PAN and channel
// - 0x05 any PAN, channel must match
// - 0x06 any channel, PAN must match
// - 0x07 accepts any beacon
// - Best link quality beacon wins
// - End device indicator solid, then 2 Hz
// - Parameter change makes end device rejoin
// - Coordinator admits only with role and bit2
// - Bit2 clear forms network, refuses joins
// - Active scan picks free or unique PAN
// - Bit0 clear uses configured PAN directly
// - Energy scan picks quietest masked channel
// - Bit1 clear uses configured channel
// - Energy scan skips occupied channels if possible
// - Coordinator parameter change re-forms network; a channel write alone does not restart it
// - Coordinator indicator solid, then 1 Hz
// - Status codes 00, 03, 0C, FF
module aic_assoc_ctrl #(
	parameter int TICK_CYCLES = aic_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Register port.
	input  wire logic [7:0]             regAddr,
	input  wire logic [31:0]            regWdata,
	input  wire logic                   regWr,
	input  wire logic                   regRd,
	output logic [31:0]                 regRdata,
	// Radio indications.
	input  wire logic                   beaconValid,
	input  wire aic_pkg::aic_beacon_t   beaconIn,
	input  wire logic [7:0]             energyLevel,
	input  wire logic                   joinRespValid,
	input  wire logic                   joinRespOk,
	input  wire logic                   joinReqIn,
	input  wire logic                   pinWake,
	// Radio requests.
	output logic                        beaconReqValid,
	output logic                        energyStart,
	output aic_pkg::aic_scan_req_t      scanReq,
	output logic                        joinReqValid,
	output logic                        formValid,
	output aic_pkg::aic_net_t           netInfo,
	output logic                        assocRespValid,
	output logic                        assocRespOk,
	output logic                        pollReq,
	output logic                        associationIndicator
);

	aic_pkg::aic_cfg_t      cfg_r, cfg_nxt;
	aic_pkg::aic_state_t    st_r, st_nxt;
	aic_pkg::aic_scan_req_t scan_nxt;
	aic_pkg::aic_net_t      net_nxt;
	logic                   cfgRestart;
	logic [4:0]             idx_r, idx_nxt;
	logic [7:0]             dur_r, dur_nxt;
	logic [15:0]            tmr_r, tmr_nxt;
	logic                   bestV_r, bestV_nxt;
	logic [7:0]             bestLqi_r, bestLqi_nxt;
	logic [15:0]            bestPan_r, bestPan_nxt;
	logic [7:0]             bestCh_r, bestCh_nxt;
	logic [15:0]            busy_r, busy_nxt;
	logic                   conflict_r, conflict_nxt;
	logic                   minV_r, minV_nxt;
	logic [7:0]             minLvl_r, minLvl_nxt;
	logic [3:0]             minIdx_r, minIdx_nxt;
	logic [7:0]             status_r, status_nxt;
	logic                   bReq_nxt, eStart_nxt, joinReq_nxt, form_nxt;
	logic                   resp_nxt, respOk_nxt, poll_nxt;
	logic [31:0]            rdata_nxt;
	logic [9:0]             blink_r, blink_nxt;
	logic                   led_nxt;
	logic                   wakeS1_r, wakeS2_r, wakeS3_r;
	logic                   tick;
	logic                   pickFound;
	logic [3:0]             pickIdx;
	logic [15:0]            freeMask, pickMask;
	logic [7:0]             curCh, listenLen;
	logic                   panOk, chOk, accept, netUp, wakeRise;

	aic_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	// Occupied channels are dropped only while a free one remains.
	assign freeMask = cfg_r.mask & ~busy_r;
	assign pickMask = (st_r == aic_pkg::ST_ESCAN && freeMask != 16'h0000) ? freeMask : cfg_r.mask;

	aic_chan_pick #(.N(aic_pkg::NUM_CH)) u_pick (
		.mask  (pickMask),
		.from  (idx_r),
		.found (pickFound),
		.idx   (pickIdx)
	);

	assign curCh     = aic_pkg::CHAN_BASE + 8'(idx_r[3:0]);
	assign listenLen = (cfg_r.scanDur == 8'h00) ? 8'h01 : cfg_r.scanDur;
	assign panOk     = cfg_r.edCfg[aic_pkg::PAN_BIT] || beaconIn.panId == cfg_r.pan;
	assign chOk      = cfg_r.edCfg[aic_pkg::CH_BIT] || curCh == cfg_r.ch;
	assign accept    = beaconValid && panOk && chOk && (!bestV_r || beaconIn.lqi > bestLqi_r);
	assign netUp     = st_r == aic_pkg::ST_JOINED || st_r == aic_pkg::ST_FORMED;
	assign wakeRise  = wakeS2_r && !wakeS3_r;

	// Configuration registers and the restart decision.
	always_comb begin
		cfg_nxt    = cfg_r;
		cfgRestart = 1'b0;
		if (regWr) begin
			case (regAddr)
				aic_pkg::ADDR_ROLE: begin
					cfg_nxt.role = regWdata[0];
					cfgRestart   = regWdata[0] != cfg_r.role;
				end
				aic_pkg::ADDR_ED_CFG: begin
					cfg_nxt.edCfg = regWdata[7:0];
					cfgRestart    = !cfg_r.role && regWdata[7:0] != cfg_r.edCfg;
				end
				aic_pkg::ADDR_CO_CFG: begin
					cfg_nxt.coCfg = regWdata[7:0];
					cfgRestart    = cfg_r.role && regWdata[7:0] != cfg_r.coCfg;
				end
				aic_pkg::ADDR_SDUR: cfg_nxt.scanDur = regWdata[7:0];
				aic_pkg::ADDR_MASK: cfg_nxt.mask = regWdata[15:0];
				aic_pkg::ADDR_PAN: begin
					cfg_nxt.pan = regWdata[15:0];
					cfgRestart  = regWdata[15:0] != cfg_r.pan;
				end
				aic_pkg::ADDR_CH: begin
					cfg_nxt.ch = regWdata[7:0];
					cfgRestart = !cfg_r.role && regWdata[7:0] != cfg_r.ch;
				end
				aic_pkg::ADDR_OWN: begin
					cfg_nxt.own = regWdata[15:0];
					cfgRestart  = cfg_r.role && regWdata[15:0] != cfg_r.own;
				end
				default: cfg_nxt = cfg_r;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= aic_pkg::CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Association sequencer.
	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		dur_nxt = dur_r;
		tmr_nxt = tmr_r;
		bestV_nxt = bestV_r;
		bestLqi_nxt = bestLqi_r;
		bestPan_nxt = bestPan_r;
		bestCh_nxt = bestCh_r;
		busy_nxt = busy_r;
		conflict_nxt = conflict_r;
		minV_nxt = minV_r;
		minLvl_nxt = minLvl_r;
		minIdx_nxt = minIdx_r;
		status_nxt = status_r;
		net_nxt = netInfo;
		scan_nxt = scanReq;
		respOk_nxt = assocRespOk;
		bReq_nxt = 1'b0;
		eStart_nxt = 1'b0;
		joinReq_nxt = 1'b0;
		form_nxt = 1'b0;
		resp_nxt = 1'b0;
		poll_nxt = 1'b0;
		case (st_r)
			aic_pkg::ST_START: begin
				idx_nxt = 5'h00;
				bestV_nxt = 1'b0;
				busy_nxt = 16'h0000;
				conflict_nxt = 1'b0;
				minV_nxt = 1'b0;
				if (!cfg_r.role) begin
					st_nxt = cfg_r.edCfg[aic_pkg::AUTO_BIT] ? aic_pkg::ST_ASCAN : aic_pkg::ST_PEER;
				end else if (cfg_r.coCfg[aic_pkg::PAN_BIT]) begin
					st_nxt = aic_pkg::ST_ASCAN;
				end else if (cfg_r.coCfg[aic_pkg::CH_BIT]) begin
					st_nxt = aic_pkg::ST_ESCAN;
				end else begin
					st_nxt = aic_pkg::ST_FORM;
				end
			end
			aic_pkg::ST_PEER: status_nxt = aic_pkg::STAT_OK;
			aic_pkg::ST_ASCAN: begin
				if (pickFound) begin
					idx_nxt = {1'b0, pickIdx};
					dur_nxt = listenLen;
					bReq_nxt = 1'b1;
					scan_nxt = '{dstAddr: aic_pkg::BCAST, dstPan: aic_pkg::BCAST,
						chan: aic_pkg::CHAN_BASE + 8'(pickIdx)};
					st_nxt = aic_pkg::ST_ALISTEN;
				end else if (!cfg_r.role) begin
					st_nxt = bestV_r ? aic_pkg::ST_JOIN : aic_pkg::ST_START;
				end else begin
					idx_nxt = 5'h00;
					st_nxt = cfg_r.coCfg[aic_pkg::CH_BIT] ? aic_pkg::ST_ESCAN : aic_pkg::ST_FORM;
				end
			end
			aic_pkg::ST_ALISTEN: begin
				if (beaconValid && cfg_r.role) begin
					busy_nxt[idx_r[3:0]] = 1'b1;
					if (beaconIn.panId == cfg_r.pan) begin
						conflict_nxt = 1'b1;
					end
				end else if (accept && !cfg_r.role) begin
					// Both reassignment bits open the filter, so 0x07 takes any beacon.
					bestV_nxt = 1'b1;
					bestLqi_nxt = beaconIn.lqi;
					bestPan_nxt = beaconIn.panId;
					bestCh_nxt = curCh;
				end
				if (tick) begin
					if (dur_r == 8'h01) begin
						idx_nxt = idx_r + 5'h01;
						st_nxt = aic_pkg::ST_ASCAN;
					end else begin
						dur_nxt = dur_r - 8'h01;
					end
				end
			end
			aic_pkg::ST_ESCAN: begin
				if (pickFound) begin
					idx_nxt = {1'b0, pickIdx};
					dur_nxt = listenLen;
					eStart_nxt = 1'b1;
					scan_nxt = '{dstAddr: aic_pkg::BCAST, dstPan: aic_pkg::BCAST,
						chan: aic_pkg::CHAN_BASE + 8'(pickIdx)};
					st_nxt = aic_pkg::ST_ELISTEN;
				end else begin
					st_nxt = aic_pkg::ST_FORM;
				end
			end
			aic_pkg::ST_ELISTEN: begin
				if (tick) begin
					if (dur_r == 8'h01) begin
						if (!minV_r || energyLevel < minLvl_r) begin
							minV_nxt = 1'b1;
							minLvl_nxt = energyLevel;
							minIdx_nxt = idx_r[3:0];
						end
						idx_nxt = idx_r + 5'h01;
						st_nxt = aic_pkg::ST_ESCAN;
					end else begin
						dur_nxt = dur_r - 8'h01;
					end
				end
			end
			aic_pkg::ST_JOIN: begin
				joinReq_nxt = 1'b1;
				net_nxt = '{panId: bestPan_r, chan: bestCh_r};
				tmr_nxt = aic_pkg::JOIN_WAIT_MS;
				st_nxt = aic_pkg::ST_JOINWAIT;
			end
			aic_pkg::ST_JOINWAIT: begin
				if (joinRespValid) begin
					status_nxt = joinRespOk ? aic_pkg::STAT_OK : aic_pkg::STAT_REFUSED;
					st_nxt = joinRespOk ? aic_pkg::ST_JOINED : aic_pkg::ST_START;
				end else if (tick) begin
					if (tmr_r == 16'h0001) begin
						status_nxt = aic_pkg::STAT_NO_RESP;
						st_nxt = aic_pkg::ST_START;
					end else begin
						tmr_nxt = tmr_r - 16'h0001;
					end
				end
			end
			aic_pkg::ST_JOINED: begin
				poll_nxt = wakeRise && cfg_r.edCfg[aic_pkg::POLL_BIT];
			end
			aic_pkg::ST_FORM: begin
				net_nxt.panId = (cfg_r.coCfg[aic_pkg::PAN_BIT] && conflict_r) ? cfg_r.pan + 16'h0001
					: cfg_r.pan;
				net_nxt.chan = (cfg_r.coCfg[aic_pkg::CH_BIT] && minV_r) ? aic_pkg::CHAN_BASE + 8'(minIdx_r)
					: cfg_r.ch;
				form_nxt = 1'b1;
				status_nxt = aic_pkg::STAT_OK;
				st_nxt = aic_pkg::ST_FORMED;
			end
			aic_pkg::ST_FORMED: begin
				if (joinReqIn) begin
					resp_nxt = 1'b1;
					respOk_nxt = cfg_r.role && cfg_r.coCfg[aic_pkg::AUTO_BIT];
				end
			end
			default: st_nxt = aic_pkg::ST_START;
		endcase
		if (cfgRestart) begin
			// A scan, join or form request raised as the restart lands would belong to an abandoned scan, so it is dropped.
			st_nxt = aic_pkg::ST_START;
			status_nxt = aic_pkg::STAT_UNKNOWN;
			bReq_nxt = 1'b0;
			eStart_nxt = 1'b0;
			joinReq_nxt = 1'b0;
			form_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= aic_pkg::ST_START;
			idx_r <= 5'h00;
			dur_r <= 8'h00;
			tmr_r <= 16'h0000;
			bestV_r <= 1'b0;
			bestLqi_r <= 8'h00;
			bestPan_r <= 16'h0000;
			bestCh_r <= 8'h00;
			busy_r <= 16'h0000;
			conflict_r <= 1'b0;
			minV_r <= 1'b0;
			minLvl_r <= 8'h00;
			minIdx_r <= 4'h0;
			status_r <= aic_pkg::STAT_UNKNOWN;
			netInfo <= '0;
			scanReq <= '0;
			beaconReqValid <= 1'b0;
			energyStart <= 1'b0;
			joinReqValid <= 1'b0;
			formValid <= 1'b0;
			assocRespValid <= 1'b0;
			assocRespOk <= 1'b0;
			pollReq <= 1'b0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			dur_r <= dur_nxt;
			tmr_r <= tmr_nxt;
			bestV_r <= bestV_nxt;
			bestLqi_r <= bestLqi_nxt;
			bestPan_r <= bestPan_nxt;
			bestCh_r <= bestCh_nxt;
			busy_r <= busy_nxt;
			conflict_r <= conflict_nxt;
			minV_r <= minV_nxt;
			minLvl_r <= minLvl_nxt;
			minIdx_r <= minIdx_nxt;
			status_r <= status_nxt;
			netInfo <= net_nxt;
			scanReq <= scan_nxt;
			beaconReqValid <= bReq_nxt;
			energyStart <= eStart_nxt;
			joinReqValid <= joinReq_nxt;
			formValid <= form_nxt;
			assocRespValid <= resp_nxt;
			assocRespOk <= respOk_nxt;
			pollReq <= poll_nxt;
		end
	end

	// Indicator: solid until the network is up, then blinking.
	always_comb begin
		blink_nxt = blink_r;
		led_nxt = associationIndicator;
		if (!netUp) begin
			blink_nxt = 10'h000;
			led_nxt = 1'b1;
		end else if (tick) begin
			if (blink_r == (cfg_r.role ? aic_pkg::CO_HALF_MS : aic_pkg::ED_HALF_MS) - 10'h001) begin
				blink_nxt = 10'h000;
				led_nxt = !associationIndicator;
			end else begin
				blink_nxt = blink_r + 10'h001;
			end
		end
	end

	// Register read data stands only in the cycle after the strobe.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (regRd) begin
			case (regAddr)
				aic_pkg::ADDR_ROLE: rdata_nxt = {31'h0, cfg_r.role};
				aic_pkg::ADDR_ED_CFG: rdata_nxt = {24'h0, cfg_r.edCfg};
				aic_pkg::ADDR_CO_CFG: rdata_nxt = {24'h0, cfg_r.coCfg};
				aic_pkg::ADDR_SDUR: rdata_nxt = {24'h0, cfg_r.scanDur};
				aic_pkg::ADDR_MASK: rdata_nxt = {16'h0, cfg_r.mask};
				aic_pkg::ADDR_PAN: rdata_nxt = {16'h0, cfg_r.pan};
				aic_pkg::ADDR_CH: rdata_nxt = {24'h0, cfg_r.ch};
				aic_pkg::ADDR_OWN: rdata_nxt = {16'h0, cfg_r.own};
				aic_pkg::ADDR_STATUS: rdata_nxt = {23'h0, netUp, status_r};
				aic_pkg::ADDR_NET: rdata_nxt = {8'h0, netInfo.chan, netInfo.panId};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			blink_r <= 10'h000;
			associationIndicator <= 1'b1;
			regRdata <= 32'h0000_0000;
			wakeS1_r <= 1'b0;
			wakeS2_r <= 1'b0;
			wakeS3_r <= 1'b0;
		end else begin
			blink_r <= blink_nxt;
			associationIndicator <= led_nxt;
			regRdata <= rdata_nxt;
			wakeS1_r <= pinWake;
			wakeS2_r <= wakeS1_r;
			wakeS3_r <= wakeS2_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence joinIssued;
		joinReqValid ##1 (st_r == aic_pkg::ST_JOINWAIT);
	endsequence

	ed_gate_a: assert property ((st_r == aic_pkg::ST_START && !cfg_r.role && !cfg_r.edCfg[2] && !cfgRestart)
		|=> st_r == aic_pkg::ST_PEER) else $error("End device left peer mode without auto bit.");
	peer_status_a: assert property ((st_r == aic_pkg::ST_PEER)[*2] |-> status_r == 8'h00)
		else $error("Peer mode status is not zero.");
	beacon_req_a: assert property (beaconReqValid |-> st_r == aic_pkg::ST_ALISTEN
		&& scanReq.dstAddr == 16'hFFFF && scanReq.chan == 8'h0B + 8'(idx_r[3:0]))
		else $error("Beacon request malformed.");
	pan_filter_a: assert property ((st_r == aic_pkg::ST_ALISTEN && !cfg_r.role && beaconValid && !bestV_r
		&& !cfg_r.edCfg[0] && beaconIn.panId != cfg_r.pan) |=> !bestV_r)
		else $error("Beacon with foreign PAN accepted.");
	best_lqi_a: assert property ((st_r == aic_pkg::ST_ALISTEN && !cfg_r.role && accept)
		|=> bestLqi_r == $past(beaconIn.lqi)) else $error("Best link quality not kept.");
	led_solid_a: assert property ((!netUp)[*2] |-> associationIndicator)
		else $error("Indicator not solid before network is up.");
	restart_a: assert property (cfgRestart |=> st_r == aic_pkg::ST_START)
		else $error("Parameter change did not restart association.");
	join_gate_a: assert property ((st_r == aic_pkg::ST_FORMED && joinReqIn && !cfgRestart)
		|=> assocRespValid && assocRespOk == $past(cfg_r.coCfg[2])) else $error("Join answer wrong.");
	form_pan_a: assert property ((formValid && !$past(cfg_r.coCfg[0])) |-> netInfo.panId == $past(cfg_r.pan))
		else $error("Network formed on an unconfigured PAN.");
	join_wait_a: assert property (disable iff (sys_rst || cfgRestart) joinReqValid |-> joinIssued)
		else $error("Join request did not start the response wait.");

endmodule // aic_assoc_ctrl

// ===== bench/aic_radio_model.sv
`timescale 1ns/1ps
module aic_radio_model (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Requests from the controller.
	input  wire logic                   beaconReqValid,
	input  wire aic_pkg::aic_scan_req_t scanReq,
	input  wire logic                   joinReqValid,
	input  wire logic                   answerJoin,
	// Indications back to the controller.
	output logic                        beaconValid,
	output aic_pkg::aic_beacon_t        beaconIn,
	output logic [7:0]                  energyLevel,
	output logic                        joinRespValid,
	output logic                        joinRespOk
);
	logic [2:0] bcnCnt;
	logic [2:0] joinCnt;
	logic [7:0] curChan;

	// Two coordinators per channel, so each filter setting picks a different winner.
	function automatic aic_pkg::aic_beacon_t beaconOf(input logic [7:0] ch, input logic second);
		case ({ch == 8'h0D, second})
			2'b00: return '{panId: 16'h2222, lqi: 8'h60};
			2'b01: return '{panId: 16'h1234, lqi: 8'h50};
			2'b10: return '{panId: 16'h1234, lqi: 8'h30};
			default: return '{panId: 16'h3333, lqi: 8'h40};
		endcase
	endfunction

	assign energyLevel = (scanReq.chan == 8'h0B) ? 8'h80 : 8'h20;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bcnCnt <= 3'h0;
			joinCnt <= 3'h0;
			curChan <= 8'h00;
			beaconValid <= 1'b0;
			beaconIn <= '0;
			joinRespValid <= 1'b0;
			joinRespOk <= 1'b0;
		end else begin
			// Released lines keep changing so that a stale value is never taken for data.
			beaconValid <= 1'b0;
			beaconIn <= ~beaconIn;
			joinRespValid <= 1'b0;
			joinRespOk <= ~joinRespOk;
			bcnCnt <= beaconReqValid ? 3'h1 : (bcnCnt == 3'h0 || bcnCnt == 3'h5) ? 3'h0 : bcnCnt + 3'h1;
			if (beaconReqValid)
				curChan <= scanReq.chan;
			if (bcnCnt == 3'h3 || bcnCnt == 3'h5) begin
				beaconValid <= 1'b1;
				beaconIn <= beaconOf(curChan, bcnCnt[1]);
			end
			joinCnt <= (joinReqValid && answerJoin) ? 3'h1 : (joinCnt == 3'h0 || joinCnt == 3'h4) ? 3'h0 : joinCnt + 3'h1;
			if (joinCnt == 3'h4) begin
				joinRespValid <= 1'b1;
				joinRespOk <= 1'b1;
			end
		end
	end
endmodule // aic_radio_model

// ===== bench/aic_assoc_ctrl_tb_top.sv
`timescale 1ns/1ps
module aic_assoc_ctrl_tb_top;
	logic                   clk = 1'b0;
	logic                   sys_rst = 1'b1;
	logic                   regWr = 1'b0;
	logic                   regRd = 1'b0;
	logic                   joinReqIn = 1'b0;
	logic                   pinWake = 1'b0;
	logic                   answer = 1'b1;
	logic [7:0]             regAddr = 8'h00;
	logic [31:0]            regWdata = 32'h0;
	logic [31:0]            regRdata, rd;
	logic                   beaconValid, joinRespValid, joinRespOk, beaconReqValid, energyStart;
	logic                   joinReqValid, formValid, assocRespValid, assocRespOk, pollReq, associationIndicator;
	logic [7:0]             energyLevel;
	logic [7:0]             prevChan = 8'h00;
	aic_pkg::aic_beacon_t   beaconIn;
	aic_pkg::aic_scan_req_t scanReq;
	aic_pkg::aic_net_t      netInfo;
	int                     fails = 0;
	int                     compares = 0;
	int                     cycles = 0;
	int                     n;
	logic [39:0]            regTab [9] = '{40'h00_00000000, 40'h04_00000000, 40'h08_00000000, 40'h0C_00000004,
		40'h10_0000FFFF, 40'h14_00001234, 40'h18_0000000C, 40'h1C_00000000, 40'h28_00000000};
	logic [31:0]            edTab [4] = '{32'h04_1234_0D, 32'h05_3333_0D, 32'h06_1234_0B, 32'h07_2222_0B};

	aic_assoc_ctrl #(.TICK_CYCLES(20)) uut (.clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.beaconValid, .beaconIn, .energyLevel, .joinRespValid, .joinRespOk, .joinReqIn, .pinWake,
		.beaconReqValid, .energyStart, .scanReq, .joinReqValid, .formValid, .netInfo, .assocRespValid,
		.assocRespOk, .pollReq, .associationIndicator);

	aic_radio_model radio (.clk, .sys_rst, .beaconReqValid, .scanReq, .joinReqValid, .answerJoin(answer),
		.beaconValid, .beaconIn, .energyLevel, .joinRespValid, .joinRespOk);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rdReg(input logic [7:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		rd = regRdata;
	endtask

	// Pulses are registered, so looking just after each edge never misses one.
	task automatic waitPulse(input int sel);
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			#1;
			if (((sel == 0) ? joinReqValid : (sel == 1) ? formValid : assocRespValid) === 1'b1)
				return;
		end
		check(32'h0, 32'h1);
	endtask

	task automatic blink(input int exp);
		logic v;
		v = associationIndicator;
		for (n = 0; n < 30000 && associationIndicator === v; n++) begin
			@(posedge clk);
			#1;
		end
		v = associationIndicator;
		for (n = 0; n < 30000 && associationIndicator === v; n++) begin
			@(posedge clk);
			#1;
		end
		check(n, exp);
	endtask

	task automatic askJoin(input logic exp);
		@(posedge clk);
		joinReqIn <= 1'b1;
		@(posedge clk);
		joinReqIn <= 1'b0;
		#1;
		check(assocRespValid, 1'b1);
		check(assocRespOk, exp);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if ((beaconReqValid | energyStart) === 1'b1) begin
			check({scanReq.dstAddr, scanReq.dstPan}, 32'hFFFFFFFF);
			check((scanReq.chan == 8'h0D) ? prevChan : scanReq.chan, 8'h0B);
			prevChan <= scanReq.chan;
		end
		if (cycles == 90000) begin
			check(32'h0, 32'h1);
			end_of_test();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (regTab[i]) begin
			rdReg(regTab[i][39:32]);
			check(rd, regTab[i][31:0]);
		end
		rdReg(aic_pkg::ADDR_STATUS);
		check(rd[7:0], 8'h00);
		check(associationIndicator, 1'b1);
		$display("Test reset and peer mode done");
		wr(aic_pkg::ADDR_MASK, 32'h5);
		wr(aic_pkg::ADDR_SDUR, 32'h2);
		wr(aic_pkg::ADDR_CH, 32'h0D);
		foreach (edTab[i]) begin
			wr(aic_pkg::ADDR_ED_CFG, {24'h0, edTab[i][31:24]});
			waitPulse(0);
			check(associationIndicator, 1'b1);
			check(netInfo, edTab[i][23:0]);
			repeat (10) @(posedge clk);
			rdReg(aic_pkg::ADDR_STATUS);
			check(rd[8:0], 9'h100);
		end
		blink(5000);
		wr(aic_pkg::ADDR_ED_CFG, 32'hF);
		waitPulse(0);
		repeat (10) @(posedge clk);
		pinWake <= 1'b1;
		repeat (3) @(posedge clk);
		pinWake <= 1'b0;
		#1;
		check(pollReq, 1'b1);
		$display("Test end device join done");
		answer <= 1'b0;
		wr(aic_pkg::ADDR_ED_CFG, 32'h5);
		waitPulse(0);
		repeat (10010) @(posedge clk);
		rdReg(aic_pkg::ADDR_STATUS);
		check(rd[7:0], 8'h0C);
		$display("Test join timeout done");
		answer <= 1'b1;
		wr(aic_pkg::ADDR_CO_CFG, 32'h3);
		wr(aic_pkg::ADDR_ROLE, 32'h1);
		rdReg(aic_pkg::ADDR_STATUS);
		check(rd[7:0], 8'hFF);
		waitPulse(1);
		check(netInfo, 24'h1235_0D);
		askJoin(1'b0);
		wr(aic_pkg::ADDR_CH, 32'h0C);
		wr(aic_pkg::ADDR_CO_CFG, 32'h4);
		waitPulse(1);
		check(netInfo, 24'h1234_0C);
		askJoin(1'b1);
		blink(10000);
		$display("Test coordinator done");
		end_of_test();
	end
endmodule // aic_assoc_ctrl_tb_top
